/* verilog/ssp_shift_port.sv */
// Synchronous serial shift port: APB registers, shift engine, pins
//
// Function
// - Status resets 0x80, top bit reads one
// - Level bit drives data-out; reads pin level
// - Data-out holds last shifted bit after transfer
// - Level override lasts until next transfer starts
// - External clock after completion sets overrun outside continuous mode, no shift
// - Overrun clears by zero write after reading one
// - Bits four-two read zero; bit one zero
// - Writing start one begins transfer; zero ignored
// - Start flag reads busy until transfer completes
// - Eight-bit: low register shifts LSB first
// - Sixteen-bit: high feeds low, input enters high
// - Internal clock drives pin; continuous mode free-running
// - External clock: pin is input, shifts follow
// - Transmit changes on fall, receive on rise
// - Both sides use LSB first order
// - Control write resets engine state and bit count
// - Completion raises transfer request flag
// - Internal clock pulses only during transfers or in continuous mode
// - Divider code picks 1024 down to 2
// - Clock-source bit selects internal or external clock
// - Control write stops running transfer
`timescale 1ns/1ns
`default_nettype none
module ssp_shift_port
  import ssp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_data_in_pin,
  output logic             serial_data_out_pin,
  output logic             serial_irq_request_flag
);
  ssp_clk_if ck ();

  // Divider runs only while a frame or the free-running mode needs it
  ssp_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .ck      (ck)
  );

  logic [7:0]  ctrl_r, ctrl_nxt;
  logic        level_r, level_nxt;
  logic        ovr_r, ovr_nxt;
  logic        ovr_seen_r, ovr_seen_nxt;
  logic [15:0] shreg_r, shreg_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  ssp_state_t  st_r, st_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        irq_r, irq_nxt;
  logic        sck_o_r, sck_o_nxt;
  logic        sck_oe_r, sck_oe_nxt;
  logic        ext_s1_r, ext_s2_r, ext_s3_r;
  logic        sin_s1_r, sin_s2_r;
  logic        wr, rd, wr_ctrl, wr_stat;
  logic        ext_mode, wide, cont_mode;
  logic        fall_ev, rise_ev;
  logic        ovr_set;
  logic [7:0]  stat_rd;
  logic [4:0]  nbits;

  // Access completes one cycle into the access phase: pready rises in its second cycle
  assign wr        = psel && penable && !pready_r && pwrite;
  assign rd        = psel && penable && !pready_r && !pwrite;
  assign wr_ctrl   = wr && (paddr == SSP_ADDR_CTRL);
  assign wr_stat   = wr && (paddr == SSP_ADDR_STAT);
  assign ext_mode  = ctrl_r[SSP_B_CSRC];
  assign wide      = ctrl_r[SSP_B_MODEL];
  assign cont_mode = ctrl_r[SSP_B_MODEU] && !ctrl_r[SSP_B_MODEL];
  assign nbits     = wide ? SSP_CNT16 : SSP_CNT8;

  assign ck.div_sel = ctrl_r[2:0];
  assign ck.run     = !ext_mode && (cont_mode || st_r != SSP_IDLE);

  // External clock edges seen through a two-stage synchroniser
  assign fall_ev = ext_mode ? (ext_s3_r && !ext_s2_r) : ck.tick_fall;
  assign rise_ev = ext_mode ? (!ext_s3_r && ext_s2_r) : ck.tick_rise;
  assign ovr_set = (st_r == SSP_IDLE) && ext_mode && fall_ev && !cont_mode;

  // Bits 4..1 read zero, bit 7 reads one, level bit reflects the pin
  assign stat_rd = {1'b1, serial_data_out_pin, ovr_r, 4'b0000,
                    (st_r != SSP_IDLE)};

  always_comb
  begin
    ctrl_nxt     = ctrl_r;
    level_nxt    = level_r;
    ovr_nxt      = ovr_r;
    ovr_seen_nxt = ovr_seen_r;
    shreg_nxt    = shreg_r;
    cnt_nxt      = cnt_r;
    st_nxt       = st_r;
    irq_nxt      = 1'b0;
    prdata_nxt   = SSP_PADDING;
    pready_nxt   = psel && penable && !pready_r;
    pslverr_nxt  = 1'b0;

    // Shift engine
    case (st_r)
      SSP_IDLE:
      begin
        if (ovr_set)
          ovr_nxt = 1'b1;
      end
      SSP_WAIT, SSP_RUN:
      begin
        if (fall_ev)
        begin
          // Shifting on the rise leaves the next bit ready for this fall
          level_nxt = shreg_r[0];
          st_nxt    = SSP_RUN;
        end
        else if (rise_ev && st_r == SSP_RUN)
        begin
          // Received bit enters at the top of the active chain
          if (wide)
            shreg_nxt = {sin_s2_r, shreg_r[15:1]};
          else
            shreg_nxt[7:0] = {sin_s2_r, shreg_r[7:1]};
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r + 5'd1 == nbits)
          begin
            st_nxt  = SSP_IDLE;
            irq_nxt = 1'b1;
          end
        end
      end
      default:
        st_nxt = SSP_IDLE;
    endcase

    // Register writes take priority over the engine for the same cycle, except a new overrun over its clear
    if (wr_ctrl)
    begin
      ctrl_nxt = pwdata[7:0];
      st_nxt   = SSP_IDLE;
      cnt_nxt  = '0;
    end
    else if (wr_stat)
    begin
      level_nxt = pwdata[SSP_B_LEVEL];
      // A new overrun in the same cycle wins over the clear
      if (!pwdata[SSP_B_OVR] && ovr_seen_r && !ovr_set)
        ovr_nxt = 1'b0;
      if (pwdata[SSP_B_OVR] == 1'b0 && ovr_seen_r)
        ovr_seen_nxt = 1'b0;
      if (pwdata[SSP_B_START] && st_r == SSP_IDLE)
      begin
        st_nxt  = SSP_WAIT;
        cnt_nxt = '0;
      end
    end
    else if (wr && paddr == SSP_ADDR_DHIGH)
      shreg_nxt[15:8] = pwdata[7:0];
    else if (wr && paddr == SSP_ADDR_DLOW)
      shreg_nxt[7:0] = pwdata[7:0];

    if (rd)
    begin
      if (paddr == SSP_ADDR_CTRL)
        prdata_nxt = {24'h00_0000, ctrl_r};
      else if (paddr == SSP_ADDR_STAT)
      begin
        prdata_nxt = {24'h00_0000, stat_rd};
        if (ovr_r)
          ovr_seen_nxt = 1'b1;
      end
      else if (paddr == SSP_ADDR_DHIGH)
        prdata_nxt = {24'h00_0000, shreg_r[15:8]};
      else if (paddr == SSP_ADDR_DLOW)
        prdata_nxt = {24'h00_0000, shreg_r[7:0]};
      else
        pslverr_nxt = 1'b1;
    end
    else if (wr && paddr != SSP_ADDR_CTRL && paddr != SSP_ADDR_STAT
             && paddr != SSP_ADDR_DHIGH && paddr != SSP_ADDR_DLOW)
      pslverr_nxt = 1'b1;

    sck_oe_nxt = !ext_mode;
    sck_o_nxt  = ck.sck;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r     <= SSP_CTRL_RST;
      level_r    <= SSP_STAT_RST[SSP_B_LEVEL];
      ovr_r      <= SSP_STAT_RST[SSP_B_OVR];
      ovr_seen_r <= 1'b0;
      shreg_r    <= '0;
      cnt_r      <= '0;
      st_r       <= SSP_IDLE;
      prdata_r   <= SSP_PADDING;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      irq_r      <= 1'b0;
      sck_o_r    <= 1'b1;
      sck_oe_r   <= 1'b0;
      ext_s1_r   <= 1'b1;
      ext_s2_r   <= 1'b1;
      ext_s3_r   <= 1'b1;
      sin_s1_r   <= 1'b0;
      sin_s2_r   <= 1'b0;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      level_r    <= level_nxt;
      ovr_r      <= ovr_nxt;
      ovr_seen_r <= ovr_seen_nxt;
      shreg_r    <= shreg_nxt;
      cnt_r      <= cnt_nxt;
      st_r       <= st_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      irq_r      <= irq_nxt;
      sck_o_r    <= sck_o_nxt;
      sck_oe_r   <= sck_oe_nxt;
      ext_s1_r   <= serial_clock_pin_i;
      ext_s2_r   <= ext_s1_r;
      ext_s3_r   <= ext_s2_r;
      sin_s1_r   <= serial_data_in_pin;
      sin_s2_r   <= sin_s1_r;
    end
  end

  // Pin holds the last shifted bit until software rewrites the level
  assign serial_data_out_pin     = level_r;
  assign serial_clock_pin_o      = sck_o_r;
  assign serial_clock_pin_oe     = sck_oe_r;
  assign serial_irq_request_flag = irq_r;
  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;

  // Checks
  property p_stat_top;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == SSP_ADDR_STAT) |=> (prdata[7] && prdata[4:1] == 4'b0000);
  endproperty
  a_stat_top: assert property (p_stat_top) else $error("status fixed bits wrong");

  property p_level;
    @(posedge pclk) disable iff (!presetn)
      (wr_stat && st_r == SSP_IDLE) |=> (serial_data_out_pin == $past(pwdata[SSP_B_LEVEL]));
  endproperty
  a_level: assert property (p_level) else $error("level bit not on pin");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (st_r == SSP_IDLE && !wr_stat) |=> $stable(serial_data_out_pin);
  endproperty
  a_hold: assert property (p_hold) else $error("idle data out changed");

  property p_ovr;
    @(posedge pclk) disable iff (!presetn)
      (st_r == SSP_IDLE && ext_mode && fall_ev && !cont_mode && !wr) |=> ovr_r;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_ovr_keep;
    @(posedge pclk) disable iff (!presetn)
      (ovr_r && !ovr_seen_r) |=> ovr_r;
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("overrun cleared unread");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      (wr_stat && pwdata[SSP_B_START] && st_r == SSP_IDLE) |=> (st_r == SSP_WAIT);
  endproperty
  a_start: assert property (p_start) else $error("start ignored");

  property p_abort;
    @(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> (st_r == SSP_IDLE && cnt_r == 5'd0);
  endproperty
  a_abort: assert property (p_abort) else $error("control write did not stop");

  property p_sck_oe;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> (serial_clock_pin_oe == !$past(ext_mode));
  endproperty
  a_sck_oe: assert property (p_sck_oe) else $error("clock pin direction wrong");

  property p_done;
    @(posedge pclk) disable iff (!presetn)
      serial_irq_request_flag |-> ($past(cnt_r) + 5'd1 == $past(nbits));
  endproperty
  a_done: assert property (p_done) else $error("wrong bit count at done");

  property p_quiet;
    @(posedge pclk) disable iff (!presetn)
      (st_r == SSP_IDLE && !ext_mode && !cont_mode) |=> ##1 serial_clock_pin_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("clock pulses while idle");

  property p_tx_edge;
    @(posedge pclk) disable iff (!presetn)
      (st_r != SSP_IDLE && !fall_ev && !wr) |=> $stable(serial_data_out_pin);
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("data out moved off a fall");

  property p_busy;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == SSP_ADDR_STAT && st_r != SSP_IDLE) |=> prdata[SSP_B_START];
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag low in transfer");

  sequence s_last_rise;
    rise_ev && st_r == SSP_RUN && (cnt_r + 5'd1 == nbits) && !wr_ctrl;
  endsequence

  property p_finish;
    @(posedge pclk) disable iff (!presetn)
      s_last_rise |=> (serial_irq_request_flag && st_r == SSP_IDLE);
  endproperty
  a_finish: assert property (p_finish) else $error("completion not signalled");

  sequence s_idle_pulse;
    st_r == SSP_IDLE && ext_mode && (fall_ev || rise_ev) && !wr;
  endsequence

  property p_ovr_still;
    @(posedge pclk) disable iff (!presetn)
      s_idle_pulse |=> $stable(shreg_r);
  endproperty
  a_ovr_still: assert property (p_ovr_still) else $error("shifted after completion");

  property p_wide_in;
    @(posedge pclk) disable iff (!presetn)
      (rise_ev && st_r == SSP_RUN && wide && !wr) |=> (shreg_r[15] == $past(sin_s2_r));
  endproperty
  a_wide_in: assert property (p_wide_in) else $error("input not at high end");
endmodule
`default_nettype wire

/* verilog/ssp_pkg.sv */
// Constants and types shared by the synchronous serial shift port
package ssp_pkg;
  // APB byte addresses (one aligned word per register)
  localparam logic [11:0] SSP_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] SSP_ADDR_STAT   = 12'h004;
  localparam logic [11:0] SSP_ADDR_DHIGH  = 12'h008;
  localparam logic [11:0] SSP_ADDR_DLOW   = 12'h00c;
  // Reset values
  localparam logic [7:0]  SSP_CTRL_RST    = 8'h00;
  localparam logic [7:0]  SSP_STAT_RST    = 8'h80;
  // Status/control bit positions
  localparam int          SSP_B_RSV1      = 7;
  localparam int          SSP_B_LEVEL     = 6;
  localparam int          SSP_B_OVR       = 5;
  localparam int          SSP_B_START     = 0;
  // Control bit positions
  localparam int          SSP_B_MODEU     = 7;
  localparam int          SSP_B_MODEL     = 6;
  localparam int          SSP_B_CSRC      = 3;
  localparam int          SSP_DIVW        = 11;
  localparam int          SSP_BITS8       = 8;
  localparam int          SSP_BITS16      = 16;
  localparam logic [4:0]  SSP_CNT8        = 5'd8;
  localparam logic [4:0]  SSP_CNT16       = 5'd16;
  localparam logic [31:0] SSP_PADDING     = 32'h0000_0000;
  // Transfer engine states, one bit changing per step along idle -> wait -> run
  typedef enum logic [1:0]
  {
    SSP_IDLE = 2'b00,
    SSP_WAIT = 2'b01,
    SSP_RUN  = 2'b11
  } ssp_state_t;
endpackage

/* verilog/ssp_clk_if.sv */
// Interface carrying the divided clock between top and divider
`timescale 1ns/1ns
`default_nettype none
interface ssp_clk_if;
  logic [2:0] div_sel;
  logic       run;
  logic       tick_fall;
  logic       tick_rise;
  logic       sck;
  modport src (input div_sel, input run, output tick_fall, output tick_rise, output sck);
  modport usr (output div_sel, output run, input tick_fall, input tick_rise, input sck);
endinterface
`default_nettype wire

/* verilog/ssp_prescaler.sv */
// Prescaler producing the internal serial clock and its edge ticks
`timescale 1ns/1ns
`default_nettype none
module ssp_prescaler
  import ssp_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  ssp_clk_if.src    ck
);
  logic [SSP_DIVW-1:0] cnt_r;
  logic [SSP_DIVW-1:0] cnt_nxt;
  logic [SSP_DIVW-1:0] half;
  logic                sck_r;
  logic                sck_nxt;
  logic                hit;

  // Code 0 -> /1024 ... code 7 -> /2; half period in pclk cycles
  always_comb
  begin
    case (ck.div_sel)
      3'd0:    half = 11'd512;
      3'd1:    half = 11'd128;
      3'd2:    half = 11'd32;
      3'd3:    half = 11'd16;
      3'd4:    half = 11'd8;
      3'd5:    half = 11'd4;
      3'd6:    half = 11'd2;
      default: half = 11'd1;
    endcase
    // Compare with >= so a smaller divider after a change never waits for wrap
    hit = ck.run && (cnt_r >= half - 11'd1);
    cnt_nxt = (!ck.run || hit) ? '0 : cnt_r + 11'd1;
    // Clock idles high so that the first edge of a frame is a fall
    sck_nxt = !ck.run ? 1'b1 : (hit ? ~sck_r : sck_r);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      sck_r <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      sck_r <= sck_nxt;
    end
  end

  assign ck.tick_fall = hit && sck_r;
  assign ck.tick_rise = hit && !sck_r;
  assign ck.sck       = sck_r;
endmodule
`default_nettype wire

/* tb/ssp_peer.sv */
// Behavioural model of the far serial party
`timescale 1ns/1ns
`default_nettype none
module ssp_peer (
  input  wire logic        pclk,
  input  wire logic        sck_o,
  input  wire logic        sck_oe,
  input  wire logic        sdo,
  input  wire logic        arm,
  input  wire logic        go,
  input  wire logic [15:0] tx,
  input  wire logic [4:0]  ext_n,
  output logic             sck,
  output logic             sdi,
  output logic      [15:0] rx
);
  logic        own_r = 1'b1;
  logic        prev_r = 1'b1;
  logic [15:0] sh_r = 16'h0000;
  logic [4:0]  left_r = 5'h00;
  logic [2:0]  ph_r = 3'h0;
  logic        sdi_r = 1'b0;
  logic [15:0] rx_r = 16'h0000;
  // Own clock idles high; period of 12 system cycles keeps it below pclk/4
  assign sck = sck_oe ? sck_o : own_r;
  assign sdi = sdi_r;
  assign rx  = rx_r;
  always @(posedge pclk)
  begin
    prev_r <= sck;
    if (arm)
    begin
      sh_r <= tx;
      rx_r <= 16'h0000;
    end
    else if (prev_r && !sck)
    begin
      sdi_r <= sh_r[0];
      // Bits past the word are inverted so a stale bit cannot pass
      sh_r <= {~sh_r[0], sh_r[15:1]};
    end
    else if (!prev_r && sck)
      rx_r <= {sdo, rx_r[15:1]};
    if (go)
      left_r <= ext_n;
    else if (left_r != 5'h00)
    begin
      ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
      if (ph_r == 3'h5)
      begin
        own_r <= ~own_r;
        if (!own_r)
          left_r <= left_r - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/sync_serial_shift_port_test.sv */
// Self-checking bench for the serial shift port
`timescale 1ns/1ns
`default_nettype none
module sync_serial_shift_port_test;
  import ssp_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        sck;
  logic        sck_o;
  logic        sck_oe;
  logic        sdi;
  logic        sdo;
  logic        irq;
  logic        sck_q = 1'b1;
  logic        arm = 1'b0;
  logic        go = 1'b0;
  logic [15:0] ptx = 16'h0000;
  logic [4:0]  pn = 5'h00;
  logic [15:0] prx;
  int          nfall = 0, nirq = 0, cyc = 0, miscompares = 0, total_checks = 0;
  int          per [8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
  ssp_shift_port uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
    .serial_data_in_pin(sdi), .serial_data_out_pin(sdo), .serial_irq_request_flag(irq)
  );
  ssp_peer peer (
    .pclk, .sck_o, .sck_oe, .sdo, .arm, .go, .tx(ptx), .ext_n(pn), .sck, .sdi, .rx(prx)
  );
  task automatic close_out();
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request holds until pready is seen high at a rising edge
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    chk("pready", 32'h0000_0001, 32'(pready));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h00_0000, d});
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task automatic wfall();
    int n;
    int k;
    n = nfall;
    k = 0;
    while (nfall == n && k < 3000)
    begin
      @(posedge pclk);
      k++;
    end
  endtask
  task automatic pulse_go();
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  // One whole transfer: data d from the port, p from the peer
  task automatic run(input logic [7:0] c, input logic [15:0] d, input logic [15:0] p,
                     input logic [4:0] en, input int bits);
    int   n0;
    int   i0;
    int   k;
    logic lvl;
    lvl = (bits == 8) ? d[7] : d[15];
    wr(SSP_ADDR_CTRL, c);
    wr(SSP_ADDR_DHIGH, d[15:8]);
    wr(SSP_ADDR_DLOW, d[7:0]);
    @(posedge pclk);
    ptx <= p;
    pn <= en;
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
    n0 = nfall;
    i0 = nirq;
    wr(SSP_ADDR_STAT, 8'h41);
    apb(SSP_ADDR_STAT, 1'b0, 32'h0000_0000);
    chk("busy", 32'h0000_0001, 32'(rd[0]));
    pulse_go();
    k = 0;
    do
    begin
      apb(SSP_ADDR_STAT, 1'b0, 32'h0000_0000);
      k++;
    end
    while (rd[0] !== 1'b0 && k < 300);
    chk("falls", bits, nfall - n0);
    chk("irq", 32'h0000_0001, nirq - i0);
    chk("sdo", 32'(lvl), 32'(sdo));
    rdc("status", SSP_ADDR_STAT, {24'h00_0000, 1'b1, lvl, 6'h00});
    if (bits == 8)
    begin
      chk("peer", 32'(d[7:0]), 32'(prx[15:8]));
      rdc("low", SSP_ADDR_DLOW, 32'(p[7:0]));
    end
    else
    begin
      chk("peer", 32'(d), 32'(prx));
      rdc("high", SSP_ADDR_DHIGH, 32'(p[15:8]));
      rdc("low", SSP_ADDR_DLOW, 32'(p[7:0]));
    end
    n0 = nfall;
    repeat (100) @(posedge pclk);
    chk("idle", n0, nfall);
  endtask
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    sck_q <= sck;
    if (sck_q && !sck)
      nfall <= nfall + 1;
    if (irq === 1'b1)
      nirq <= nirq + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  initial
  begin
    int n0;
    int t0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", SSP_ADDR_CTRL, {24'h00_0000, SSP_CTRL_RST});
    rdc("status", SSP_ADDR_STAT, 32'h0000_0080);
    chk("oe", 32'h0000_0001, 32'(sck_oe));
    apb(12'h010, 1'b0, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, 32'(err));
    wr(SSP_ADDR_STAT, 8'h7c);
    rdc("status", SSP_ADDR_STAT, 32'h0000_00c0);
    chk("sdo", 32'h0000_0001, 32'(sdo));
    wr(SSP_ADDR_STAT, 8'h00);
    rdc("status", SSP_ADDR_STAT, 32'h0000_0080);
    chk("sdo", 32'h0000_0000, 32'(sdo));
    run(8'h04, 16'h00a5, 16'h003c, 5'h00, 8);
    run(8'h44, 16'h1234, 16'hbeef, 5'h00, 16);
    run(8'h08, 16'h005a, 16'h00c3, 5'h08, 8);
    chk("oe", 32'h0000_0000, 32'(sck_oe));
    pn <= 5'h01;
    pulse_go();
    repeat (40) @(posedge pclk);
    rdc("overrun", SSP_ADDR_STAT, 32'h0000_00a0);
    rdc("low", SSP_ADDR_DLOW, 32'h0000_00c3);
    wr(SSP_ADDR_STAT, 8'h20);
    rdc("overrun", SSP_ADDR_STAT, 32'h0000_00a0);
    wr(SSP_ADDR_STAT, 8'h00);
    rdc("overrun", SSP_ADDR_STAT, 32'h0000_0080);
    wr(SSP_ADDR_CTRL, 8'h02);
    wr(SSP_ADDR_STAT, 8'h01);
    wfall();
    wfall();
    wr(SSP_ADDR_CTRL, 8'h02);
    apb(SSP_ADDR_STAT, 1'b0, 32'h0000_0000);
    chk("abort", 32'h0000_0000, 32'(rd[0]));
    n0 = nfall;
    repeat (300) @(posedge pclk);
    chk("abort", n0, nfall);
    for (int i = 0; i < 8; i++)
    begin
      wr(SSP_ADDR_CTRL, 8'h80 | 8'(i));
      wfall();
      t0 = cyc;
      wfall();
      chk("period", per[i], cyc - t0);
    end
    close_out();
  end
endmodule
`default_nettype wire
